// file: aitg_params.svh
// constants for the aux i2c transaction generator controller
`ifndef AITG_PARAMS_SVH
`define AITG_PARAMS_SVH

// register offsets inside the device
`define AITG_OFS_CMD 12'h100
`define AITG_OFS_WFIFO 12'h104
`define AITG_OFS_ADDR 12'h108

// command register field layout
`define AITG_LEN_LSB 0
`define AITG_LEN_W 4
`define AITG_CODE_LSB 8
`define AITG_CODE_W 3
`define AITG_ADDR_ONLY_BIT 12
`define AITG_CONT_CODE_BIT 2

// transaction codes with the continue flag clear
`define AITG_CODE_WRITE 3'h0
`define AITG_CODE_READ 3'h1
`define AITG_CODE_STATUS 3'h2

// data buffer shape and reset values
`define AITG_FIFO_DEPTH 16
`define AITG_FIFO_WIDTH 8
`define AITG_RST_WORD 32'h0000_0000
`define AITG_RST_OFS 12'h000

`endif

// file: aitg_pkg.sv
// types shared by the aux i2c transaction generator controller
package aitg_pkg;

    // kind of transaction asked for by the user
    typedef enum logic [1:0] {
        AITG_KIND_WRITE,
        AITG_KIND_READ,
        AITG_KIND_STATUS
    } aitg_kind_t;

    // reply class reported by the device, in this code order
    typedef enum logic [1:0] {
        AITG_REP_ACK,
        AITG_REP_NACK,
        AITG_REP_DEFER,
        AITG_REP_PARTIAL
    } aitg_reply_t;

    // one user request
    typedef struct packed {
        aitg_kind_t kind;
        logic continueTransactionFlag;
        logic addrOnly;
        logic [3:0] len;
        logic [31:0] devAddr;
    } aitg_req_t;

endpackage : aitg_pkg

// file: aitg_ctrl.sv
// data fifo and host-side sequencer driving the aux i2c registers
`timescale 1ns/1ns
`default_nettype none
`include "aitg_params.svh"


module aitg_fifo #(
    parameter int WIDTH = `AITG_FIFO_WIDTH,
    parameter int DEPTH = `AITG_FIFO_DEPTH
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic inValid, // producer offers a word
    output logic inReady, // room for a word
    input wire logic [WIDTH-1:0] inData, // word offered
    output logic outValid, // a word is waiting
    input wire logic outReady, // consumer takes the word
    output logic [WIDTH-1:0] outData // oldest word
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wrPtr_q;
    logic [PW-1:0] rdPtr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;

    // pointer step with wrap, used by both ends
    function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : nextPtr

    assign push = inValid && inReady;
    assign pop = outReady && outValid;
    assign count_d = count_q + CW'(push) - CW'(pop);
    assign outData = mem_q[rdPtr_q];

    // storage is written only, never reset, to save reset fan-out
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    // pointers, count and registered flags
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            if (pop) begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
            count_q <= count_d;
            inReady <= (count_d != CW'(DEPTH));
            outValid <= (count_d != '0);
        end
    end
endmodule : aitg_fifo

module aitg_ctrl
    import aitg_pkg::*;
(
    input wire logic clk_sys, // system clock, 125 MHz
    input wire logic reset_n, // synchronous reset, active low
    input wire logic reqValid, // user offers a request
    input wire aitg_req_t reqData, // request fields
    output logic reqReady, // sequencer idle, request taken when valid
    input wire logic dataValid, // user offers a payload byte
    input wire logic [`AITG_FIFO_WIDTH-1:0] dataByte, // payload byte
    output logic dataReady, // payload buffer has room
    output logic done, // one-cycle pulse when a reply arrived
    output aitg_reply_t replyClass, // class of the last reply
    output logic pendingWrite, // a write is deferred or partially acknowledged
    output logic pendingRead, // a read is deferred
    output logic devWrEn, // device register write strobe
    output logic [11:0] devAddr, // device register offset
    output logic [31:0] devWrData, // device register write data
    input wire logic devReplyValid, // device saw an aux reply
    input wire aitg_reply_t devReplyCode // class of that reply
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_CMD, S_WAIT} aitg_state_t;

    aitg_state_t state_q;
    aitg_req_t req_q;
    logic [3:0] left_q;
    logic fifoValid;
    logic fifoTake;
    logic [`AITG_FIFO_WIDTH-1:0] fifoByte;
    logic burstWrite;
    logic replyNow;

    // command code: base by kind, continue flag adds four
    function automatic logic [2:0] cmdCode(input aitg_req_t r);
        logic [2:0] c;
        c = `AITG_CODE_WRITE;
        if (r.kind == AITG_KIND_READ) begin
            c = `AITG_CODE_READ;
        end else if (r.kind == AITG_KIND_STATUS) begin
            c = `AITG_CODE_STATUS;
        end
        c[`AITG_CONT_CODE_BIT] = r.continueTransactionFlag;
        return c;
    endfunction : cmdCode

    // command register word; status always goes out address-only
    function automatic logic [31:0] cmdWord(input aitg_req_t r);
        logic [31:0] w;
        w = `AITG_RST_WORD;
        w[`AITG_CODE_LSB +: `AITG_CODE_W] = cmdCode(r);
        w[`AITG_ADDR_ONLY_BIT] = r.addrOnly || (r.kind == AITG_KIND_STATUS);
        if (!w[`AITG_ADDR_ONLY_BIT]) begin
            w[`AITG_LEN_LSB +: `AITG_LEN_W] = r.len;
        end
        return w;
    endfunction : cmdWord

    // payload only moves for a burst write, and only while the block drains it
    assign burstWrite = (req_q.kind == AITG_KIND_WRITE) && !req_q.addrOnly;
    assign fifoTake = (state_q == S_DATA) && (left_q != 4'h0);
    assign replyNow = (state_q == S_WAIT) && devReplyValid;

    aitg_fifo #(
        .WIDTH(`AITG_FIFO_WIDTH),
        .DEPTH(`AITG_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inValid(dataValid),
        .inReady(dataReady),
        .inData(dataByte),
        .outValid(fifoValid),
        .outReady(fifoTake),
        .outData(fifoByte)
    );

    // launch sequencer: address, optional payload, command, then wait
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q <= S_IDLE;
            req_q <= '0;
            left_q <= 4'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (reqValid) begin
                        req_q <= reqData;
                        left_q <= reqData.len;
                        state_q <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    state_q <= burstWrite ? S_DATA : S_CMD;
                end
                S_DATA: begin
                    if (left_q == 4'h0) begin
                        state_q <= S_CMD;
                    end else if (fifoValid) begin
                        left_q <= left_q - 4'h1;
                    end
                end
                S_CMD: begin
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (devReplyValid) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // device register writes, one per cycle, issued from the sequencer
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            devWrEn <= 1'b0;
            devAddr <= `AITG_RST_OFS;
            devWrData <= `AITG_RST_WORD;
        end else begin
            devWrEn <= 1'b0;
            if (state_q == S_IDLE && reqValid) begin
                devWrEn <= 1'b1;
                devAddr <= `AITG_OFS_ADDR;
                devWrData <= reqData.devAddr;
            end else if (state_q == S_DATA && left_q != 4'h0 && fifoValid) begin
                devWrEn <= 1'b1;
                devAddr <= `AITG_OFS_WFIFO;
                devWrData <= 32'(fifoByte);
            end else if (state_q == S_CMD) begin
                devWrEn <= 1'b1;
                devAddr <= `AITG_OFS_CMD;
                devWrData <= cmdWord(req_q);
            end
        end
    end

    // user handshake and reply report
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reqReady <= 1'b0;
            done <= 1'b0;
            replyClass <= AITG_REP_ACK;
        end else begin
            reqReady <= (state_q == S_IDLE && !reqValid) || replyNow;
            done <= replyNow;
            if (replyNow) begin
                replyClass <= devReplyCode;
            end
        end
    end

    // pending state of the remote bridge, so the user knows to poll, retry or abort
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pendingWrite <= 1'b0;
            pendingRead <= 1'b0;
        end else if (replyNow) begin
            if (req_q.kind == AITG_KIND_STATUS) begin
                // polls keep the write pending while it still crawls
                pendingWrite <= (devReplyCode == AITG_REP_PARTIAL) ||
                    (devReplyCode == AITG_REP_DEFER);
            end else if (req_q.addrOnly) begin
                pendingWrite <= 1'b0;
                pendingRead <= 1'b0;
            end else if (req_q.kind == AITG_KIND_WRITE) begin
                pendingWrite <= (devReplyCode == AITG_REP_PARTIAL) ||
                    (devReplyCode == AITG_REP_DEFER);
                pendingRead <= 1'b0;
            end else begin
                pendingRead <= (devReplyCode == AITG_REP_DEFER);
                pendingWrite <= 1'b0;
            end
        end
    end

    // count payload writes since the address write, for checking only
    logic [4:0] payCount_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            payCount_q <= 5'h00;
        end else if (devWrEn && devAddr == `AITG_OFS_ADDR) begin
            payCount_q <= 5'h00;
        end else if (devWrEn && devAddr == `AITG_OFS_WFIFO) begin
            payCount_q <= payCount_q + 5'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_take;
        state_q == S_IDLE && reqValid;
    endsequence
    sequence s_addrWrite;
        devWrEn && devAddr == `AITG_OFS_ADDR;
    endsequence
    sequence s_cmdWrite;
        devWrEn && devAddr == `AITG_OFS_CMD;
    endsequence

    chk_addr_first: assert property (s_take |=> s_addrWrite)
        else $error("address register not written first");
    chk_cmd_code: assert property (s_cmdWrite |->
        devWrData[`AITG_CODE_LSB +: `AITG_CODE_W] == cmdCode(req_q))
        else $error("wrong command code");
    chk_status_bit: assert property ((s_cmdWrite and (req_q.kind == AITG_KIND_STATUS)) |->
        devWrData[`AITG_ADDR_ONLY_BIT])
        else $error("status without address-only bit");
    chk_payload_count: assert property (s_cmdWrite |->
        payCount_q == (burstWrite ? {1'b0, req_q.len} : 5'h00))
        else $error("payload count does not match length");
    chk_read_nofifo: assert property (state_q == S_DATA |-> burstWrite)
        else $error("fifo drained for a non-write");
    chk_hold_launch: assert property (state_q == S_WAIT && !devReplyValid |=>
        !reqReady && !devWrEn)
        else $error("new launch before reply");
    chk_reply_report: assert property (replyNow |=>
        done && replyClass == $past(devReplyCode) ##1 !done)
        else $error("reply not reported");
    chk_read_defer: assert property (replyNow && req_q.kind == AITG_KIND_READ &&
        !req_q.addrOnly && devReplyCode == AITG_REP_DEFER |=> pendingRead && !pendingWrite)
        else $error("deferred read not pending");
    chk_abort_clear: assert property (replyNow && req_q.addrOnly &&
        req_q.kind != AITG_KIND_STATUS |=> !pendingRead && !pendingWrite)
        else $error("abort left a pending transaction");
    chk_partial_pend: assert property (replyNow && req_q.kind != AITG_KIND_READ &&
        !req_q.addrOnly && devReplyCode == AITG_REP_PARTIAL |=> pendingWrite)
        else $error("partial write not pending");
endmodule : aitg_ctrl

`default_nettype wire

// file: aitg_dev_model.sv
// behavioural model of the device registers and its aux reply path
`timescale 1ns/1ns
`default_nettype none
`include "aitg_params.svh"

module aitg_dev_model
    import aitg_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic devWrEn, // register write strobe
    input wire logic [11:0] devAddr, // register offset
    input wire logic [31:0] devWrData, // register write data
    input wire aitg_reply_t replyCode, // reply class the bench wants sent
    input wire logic [7:0] replyDelay, // cycles from command to reply, at least 1
    output logic devReplyValid, // reply pulse
    output aitg_reply_t devReplyCode // reply class
);
    logic [31:0] addrReg; // target address register
    logic [31:0] cmdReg; // command register
    logic [7:0] wBytes [0:63]; // bytes written to the write fifo, in order; the index wraps, so only the last 64 are kept
    int wCount; // bytes written so far
    int cmdCount; // commands launched so far
    logic [7:0] countQ; // reply countdown

    // decode writes; a command arms the reply, which comes whatever the code
    // because write, read and status all get exactly one reply each;
    // the bounded countdown also stands in for the receiver releasing a stuck bus
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            addrReg <= 32'h0000_0000;
            cmdReg <= 32'h0000_0000;
            wCount <= 0;
            cmdCount <= 0;
            countQ <= 8'h00;
            devReplyValid <= 1'b0;
            devReplyCode <= AITG_REP_ACK;
        end else begin
            devReplyValid <= 1'b0;
            if (countQ != 8'h00) begin
                countQ <= countQ - 8'h01;
            end
            if (countQ == 8'h01) begin
                devReplyValid <= 1'b1;
                devReplyCode <= replyCode;
            end
            if (devWrEn && devAddr == `AITG_OFS_ADDR) begin
                addrReg <= devWrData;
            end
            if (devWrEn && devAddr == `AITG_OFS_WFIFO) begin
                wBytes[wCount[5:0]] <= devWrData[7:0];
                wCount <= wCount + 1;
            end
            if (devWrEn && devAddr == `AITG_OFS_CMD) begin
                cmdReg <= devWrData;
                cmdCount <= cmdCount + 1;
                countQ <= replyDelay;
            end
        end
    end
endmodule : aitg_dev_model
`default_nettype wire

// file: aitg_ctrl_test.sv
// self-checking bench for the aux i2c transaction controller
`timescale 1ns/1ns
`default_nettype none

module aitg_ctrl_test
    import aitg_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic reqValid = 1'b0;
    aitg_req_t reqData = '0;
    logic dataValid = 1'b0;
    logic [7:0] dataByte = 8'h00;
    logic reqReady, dataReady, done, pendingWrite, pendingRead, devWrEn, devReplyValid;
    aitg_reply_t replyClass, devReplyCode;
    aitg_reply_t repSel = AITG_REP_ACK;
    logic [7:0] repDly = 8'h03;
    logic [11:0] devAddr;
    logic [31:0] devWrData;
    int fails = 0;
    int tests_run = 0;

    aitg_ctrl dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reqValid(reqValid),
        .reqData(reqData), .reqReady(reqReady), .dataValid(dataValid), .dataByte(dataByte),
        .dataReady(dataReady), .done(done), .replyClass(replyClass),
        .pendingWrite(pendingWrite), .pendingRead(pendingRead), .devWrEn(devWrEn),
        .devAddr(devAddr), .devWrData(devWrData), .devReplyValid(devReplyValid),
        .devReplyCode(devReplyCode));
    aitg_dev_model model_u (.clk_sys(clk_sys), .reset_n(reset_n), .devWrEn(devWrEn),
        .devAddr(devAddr), .devWrData(devWrData), .replyCode(repSel), .replyDelay(repDly),
        .devReplyValid(devReplyValid), .devReplyCode(devReplyCode));

    // 125 MHz
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // bounded wait at falling edges for a flag
    task automatic wait_hi(ref logic flag);
        int k;
        for (k = 0; k < 400 && flag !== 1'b1; k++) @(negedge clk_sys);
        if (k == 400) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_hi

    // payload bytes base, base+1, ... held valid back to back
    task automatic push_bytes(input int n, input logic [7:0] base);
        @(negedge clk_sys);
        dataValid = 1'b1;
        for (int i = 0; i < n; i++) begin
            dataByte = base + i[7:0];
            wait_hi(dataReady);
            @(negedge clk_sys);
        end
        dataValid = 1'b0;
    endtask : push_bytes

    // one request, its command word checked against the code table
    task automatic issue(input aitg_kind_t k, input logic c, input logic ao, input logic [3:0] n,
            input logic [31:0] a, input aitg_reply_t rep);
        logic [31:0] w;
        w = {19'h0, ao || k == AITG_KIND_STATUS, 1'b0, c, 2'(k), 4'h0,
            (ao || k == AITG_KIND_STATUS) ? 4'h0 : n};
        @(negedge clk_sys);
        repSel = rep;
        reqData = '{kind: k, continueTransactionFlag: c, addrOnly: ao, len: n, devAddr: a};
        reqValid = 1'b1;
        wait_hi(reqReady);
        @(negedge clk_sys);
        reqValid = 1'b0;
        chk(reqReady, 1'b0);
        wait_hi(done);
        chk(model_u.addrReg, a);
        chk(model_u.cmdReg, w);
        chk(replyClass, rep);
    endtask : issue

    task automatic s_burst_write;
        int b;
        b = model_u.wCount;
        push_bytes(2, 8'ha5);
        issue(AITG_KIND_WRITE, 1'b0, 1'b0, 4'h2, 32'h0000_0050, AITG_REP_ACK);
        chk(model_u.wCount - b, 2);
        chk(model_u.wBytes[b], 8'ha5);
        chk(model_u.wBytes[b + 1], 8'ha6);
        chk(pendingWrite, 1'b0);
    endtask : s_burst_write

    // every code with the continue flag both ways
    task automatic s_codes;
        for (int c = 0; c < 2; c++) begin
            issue(AITG_KIND_WRITE, c[0], 1'b0, 4'h0, 32'h0000_0011, AITG_REP_ACK);
            issue(AITG_KIND_READ, c[0], 1'b0, 4'h3, 32'h0000_0012, AITG_REP_ACK);
            issue(AITG_KIND_STATUS, c[0], 1'b0, 4'h0, 32'h0000_0013, AITG_REP_ACK);
            issue(AITG_KIND_READ, c[0], 1'b1, 4'h5, 32'h0000_0014, AITG_REP_ACK);
        end
    endtask : s_codes

    task automatic s_pending;
        push_bytes(1, 8'h30);
        issue(AITG_KIND_WRITE, 1'b0, 1'b0, 4'h1, 32'h0000_0020, AITG_REP_DEFER);
        chk(pendingWrite, 1'b1);
        issue(AITG_KIND_STATUS, 1'b1, 1'b0, 4'h0, 32'h0000_0020, AITG_REP_PARTIAL);
        chk(pendingWrite, 1'b1);
        issue(AITG_KIND_STATUS, 1'b0, 1'b0, 4'h0, 32'h0000_0020, AITG_REP_NACK);
        chk(pendingWrite, 1'b0);
        issue(AITG_KIND_READ, 1'b0, 1'b0, 4'h4, 32'h0000_0021, AITG_REP_DEFER);
        issue(AITG_KIND_READ, 1'b0, 1'b0, 4'h4, 32'h0000_0021, AITG_REP_DEFER);
        chk(pendingRead, 1'b1);
        issue(AITG_KIND_WRITE, 1'b0, 1'b0, 4'h0, 32'h0000_0022, AITG_REP_PARTIAL);
        chk(pendingRead, 1'b0);
        chk(pendingWrite, 1'b1);
        issue(AITG_KIND_READ, 1'b0, 1'b0, 4'h2, 32'h0000_0023, AITG_REP_ACK);
        chk(pendingWrite, 1'b0);
        issue(AITG_KIND_READ, 1'b0, 1'b0, 4'h2, 32'h0000_0024, AITG_REP_DEFER);
        chk(pendingRead, 1'b1);
        issue(AITG_KIND_WRITE, 1'b0, 1'b1, 4'h0, 32'h0000_0024, AITG_REP_ACK);
        chk(pendingRead, 1'b0);
    endtask : s_pending

    // fill the buffer until it refuses, then drain with a slow reply
    task automatic s_fifo;
        int b;
        b = model_u.wCount;
        push_bytes(16, 8'h40);
        @(negedge clk_sys);
        chk(dataReady, 1'b0);
        repDly = 8'h28;
        issue(AITG_KIND_WRITE, 1'b1, 1'b0, 4'hf, 32'h0000_0060, AITG_REP_ACK);
        issue(AITG_KIND_WRITE, 1'b0, 1'b0, 4'h1, 32'h0000_0060, AITG_REP_ACK);
        chk(model_u.wCount - b, 16);
        chk(model_u.wBytes[b + 15], 8'h4f);
        chk(dataReady, 1'b1);
        repDly = 8'h03;
    endtask : s_fifo

    initial begin
        repeat (12) @(negedge clk_sys);
        chk(reqReady, 1'b0);
        chk(devWrEn, 1'b0);
        reset_n = 1'b1;
        s_burst_write();
        s_codes();
        s_pending();
        s_fifo();
        report_and_stop();
    end
endmodule : aitg_ctrl_test
`default_nettype wire
